/* File: logic/sbt_if.sv */
// Purpose: scan link between tester and test port
// Assumes: tdo has no pull, so a floated tdo shows the inverse of what the port last put out
// Notes: tms and tdi read high when undriven, as the pull-ups do on the pins
interface sbt_if;
    logic tck;
    logic tms;
    logic tms_oe_n;
    logic tdi;
    logic tdi_oe_n;
    logic tdo_out;
    logic tdo_oe_n;
    wire  tms_pin;
    wire  tdi_pin;
    wire  tdo_pin;

    // pull-ups on the inputs
    assign tms_pin = tms_oe_n ? 1'b1 : tms;
    assign tdi_pin = tdi_oe_n ? 1'b1 : tdi;
    // floated tdo reads as a wrong bit, so sampling it outside a shift cannot pass unnoticed
    assign tdo_pin = tdo_oe_n ? ~tdo_out : tdo_out;

    modport dev  (input tck, input tms_pin, input tdi_pin, output tdo_out, output tdo_oe_n);
    modport host (output tck, output tms, output tms_oe_n, output tdi, output tdi_oe_n, input tdo_pin);
endinterface

/* File: logic/sbt_pkg.sv */
// Purpose: shared constants and types for the boundary-scan test port and its tester
// Assumes: tck is the link clock made by the tester end
// Notes: instruction codes, register sizes and the state machine are common to both ends
package sbt_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int IR_W          = 3;
    localparam int ID_W          = 32;
    localparam int BSR_W         = 109;
    localparam int BSR_OE_CELL   = 108;
    localparam int RESET_TMS_CNT = 5;
    localparam int CNT_W         = 8;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] INS_EXTEST   = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE   = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;
    localparam logic [1:0]      IR_CAPTURE   = 2'h1;

    // identification word: revision, part, maker, presence bit (values arbitrary)
    localparam logic [ID_W-1:0] ID_VALUE_DEF = 32'h0012_3455;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } sbt_state_e;

    // standard sixteen-state transition table
    function automatic sbt_state_e sbt_next(input sbt_state_e s, input logic tms);
        sbt_state_e n;
        n = ST_RESET;
        case (s)
            ST_RESET:  n = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
            default:   n = ST_RESET;
        endcase
        return n;
    endfunction

endpackage

/* File: logic/sbt_tap.sv */
// Purpose: boundary-scan test port of the memory, clocked by tck
// Assumes: core_clk_i domain holds the memory pins; tck comes from the tester
// Notes: bsr update and output control cross to core_clk_i through two flops
//
// What this block, its scan link and its tester do
// R01 - sample on tck rise, drive on fall
// R02 - tms steers controller; tms/tdi pulled high
// R03 - data enters msb, leaves lsb
// R04 - power-up reset floats tdo, memory untouched
// R05 - five tms-high edges reset the port
// R06 - one register between tdi and tdo
// R07 - three-bit instruction, idcode after reset
// R08 - capture-ir loads 01 into low bits
// R09 - one-bit bypass, cleared at capture
// R10 - boundary register captures pins, shifts
// R11 - idcode captures 32-bit id value
// R12 - instruction takes effect at update-ir
// R13 - tester never loads reserved codes
// R14 - sample-z floats read bus, shifts boundary
// R15 - sample captures pins, memory untouched
// R16 - update-dr latches preload, concurrent shift
// R17 - extest drives preloaded values out
// R18 - cell 108 enables bus under extest
// R19 - control cell preset low at reset
// R20 - tester keeps tck at most 20 MHz
// R21 - codes 000,001,010,100,111; rest reserved
// R22 - standard sixteen-state controller
// R23 - tdo driven only in shift states
module sbt_tap
    import sbt_pkg::*;
#(
    parameter logic [sbt_pkg::ID_W-1:0] ID_VALUE = sbt_pkg::ID_VALUE_DEF
)(
    // core side
    input  wire logic                     core_clk_i,
    input  wire logic                     srst_i,
    input  wire logic [sbt_pkg::BSR_W-1:0] pins_i,
    output logic      [sbt_pkg::BSR_W-1:0] pins_o,
    output logic                          test_drive_o,
    output logic                          q_float_o,
    // scan link
    sbt_if.dev                            link
);
    import sbt_pkg::*;

    // ------------------------------------------------------------
    // power-up reset in the tck domain
    // ------------------------------------------------------------
    // tck may stand still, so the core reset is carried over by two flops
    logic       rst_m;
    logic       rst_t;
    logic [2:0] tms_hi;
    sbt_state_e state;
    logic [IR_W-1:0]  ir_sh;
    logic [IR_W-1:0]  ir;
    logic             byp;
    logic [ID_W-1:0]  id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic             upd_tgl;
    logic             tdo_bit;
    logic             tdo_oe_n;

    always_ff @(posedge link.tck)
    begin
        rst_m <= srst_i;
        rst_t <= rst_m;
    end

    // ------------------------------------------------------------
    // controller
    // ------------------------------------------------------------
    always_ff @(posedge link.tck)
    begin
        if (rst_t)
            state <= ST_RESET; // R04
        else
            state <= sbt_next(state, link.tms_pin); // R02 R22
    end

    // counter of consecutive tms-high edges; the table already reaches reset in five
    always_ff @(posedge link.tck)
    begin
        if (rst_t || !link.tms_pin)
            tms_hi <= 3'h0;
        else if (tms_hi != 3'(RESET_TMS_CNT))
            tms_hi <= tms_hi + 3'h1;
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    always_ff @(posedge link.tck)
    begin
        if (state == ST_CAP_IR)
            ir_sh <= {ir[IR_W-1:2], IR_CAPTURE}; // R08
        else if (state == ST_SH_IR)
            ir_sh <= {link.tdi_pin, ir_sh[IR_W-1:1]}; // R03
    end

    always_ff @(posedge link.tck)
    begin
        if (rst_t || state == ST_RESET || tms_hi == 3'(RESET_TMS_CNT))
            ir <= INS_IDCODE; // R05 R07
        else if (state == ST_UPD_IR)
            ir <= ir_sh; // R12 R21
    end

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    always_ff @(posedge link.tck)
    begin
        if (state == ST_CAP_DR)
            byp <= 1'b0; // R09
        else if (state == ST_SH_DR)
            byp <= link.tdi_pin;
    end

    always_ff @(posedge link.tck)
    begin
        if (state == ST_CAP_DR)
            id_sh <= ID_VALUE; // R11
        else if (state == ST_SH_DR)
            id_sh <= {link.tdi_pin, id_sh[ID_W-1:1]};
    end

    // pins are sampled straight; capture setup and hold are the tester's job
    always_ff @(posedge link.tck)
    begin
        if (state == ST_CAP_DR)
            bsr_sh <= pins_i; // R10 R15
        else if (state == ST_SH_DR)
            bsr_sh <= {link.tdi_pin, bsr_sh[BSR_W-1:1]}; // R03 R16
    end

    always_ff @(posedge link.tck)
    begin
        if (rst_t || state == ST_RESET)
            bsr_upd[BSR_OE_CELL] <= 1'b0; // R19
        else if (state == ST_UPD_DR && ir != INS_IDCODE && ir != INS_BYPASS)
            bsr_upd[BSR_OE_CELL] <= bsr_sh[BSR_OE_CELL]; // R16
    end

    always_ff @(posedge link.tck)
    begin
        if (state == ST_UPD_DR && ir != INS_IDCODE && ir != INS_BYPASS)
            bsr_upd[BSR_OE_CELL-1:0] <= bsr_sh[BSR_OE_CELL-1:0]; // R16
    end

    // update toggle tells the core a new preload pattern is stable; it is cleared in reset because
    // srst_i never reaches this domain while tck stands still; update-ir toggles too, so the preset
    // control cell is carried over before extest can use it
    always_ff @(posedge link.tck)
    begin
        if (rst_t || state == ST_RESET)
            upd_tgl <= 1'b0;
        else if (state == ST_UPD_DR || state == ST_UPD_IR)
            upd_tgl <= ~upd_tgl;
    end

    // ------------------------------------------------------------
    // serial output, changed on the falling edge
    // ------------------------------------------------------------
    always_ff @(negedge link.tck)
    begin
        if (rst_t)
            tdo_oe_n <= 1'b1; // R04
        else
            tdo_oe_n <= !(state == ST_SH_IR || state == ST_SH_DR); // R01 R23
    end

    // outside the shift states a fixed level is put out, so an unloaded register never reaches the pin
    always_ff @(negedge link.tck)
    begin
        if (state == ST_SH_IR)
            tdo_bit <= ir_sh[0];
        else if (state == ST_SH_DR)
        begin
            case (ir) // R06
                INS_IDCODE:                           tdo_bit <= id_sh[0];
                INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE: tdo_bit <= bsr_sh[0];
                default:                              tdo_bit <= byp;
            endcase
        end
        else
            tdo_bit <= 1'b0;
    end

    assign link.tdo_out  = tdo_bit;
    assign link.tdo_oe_n = tdo_oe_n;

    // ------------------------------------------------------------
    // core domain: controls and preload pattern
    // ------------------------------------------------------------
    // levels through two flops; the pattern word follows the toggle, so it is stable when taken
    logic [IR_W-1:0] ir_m;
    logic [IR_W-1:0] ir_c;
    logic [IR_W-1:0] ir_d;
    logic [IR_W-1:0] ir_q;
    logic [2:0]      tg_s;

    always_ff @(posedge core_clk_i)
    begin
        ir_m <= ir;
        ir_c <= ir_m;
        ir_d <= ir_c;
    end

    // the code is taken only when two samples agree, so bits skewed across a change never show
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            ir_q <= INS_IDCODE;
        else if (ir_c == ir_d)
            ir_q <= ir_d;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            tg_s <= 3'h0;
        else
            tg_s <= {tg_s[1:0], upd_tgl};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            pins_o <= '0;
        else if (tg_s[2] != tg_s[1])
            pins_o <= bsr_upd; // R17
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            test_drive_o <= 1'b0;
            q_float_o    <= 1'b0;
        end
        else
        begin
            test_drive_o <= (ir_q == INS_EXTEST); // R17
            q_float_o    <= (ir_q == INS_SAMPLE_Z) || // R14
                            (ir_q == INS_EXTEST && !pins_o[BSR_OE_CELL]); // R18
        end
    end

endmodule

/* File: logic/sbt_tester.sv */
// Purpose: simple tester end: runs tms/tdi sequences and shifts one register
// Assumes: tck made from core_clk_i by a divider, at most 20 MHz
// Notes: one request walks idle -> shift -> update -> idle; loads of reserved codes are turned into bypass
module sbt_tester
    import sbt_pkg::*;
#(
    parameter int DIV = 2
)(
    // clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    srst_i,
    // request
    input  wire logic                    req_i,
    input  wire logic                    req_ir_i,
    input  wire logic                    req_reset_i,
    input  wire logic [CNT_W-1:0]        req_len_i,
    input  wire logic [BSR_W-1:0]        req_data_i,
    output logic                         busy_o,
    output logic                         done_o,
    output logic      [BSR_W-1:0]        resp_data_o,
    // scan link
    sbt_if.host                          link
);
    import sbt_pkg::*;

    // ------------------------------------------------------------
    // clock divider: tck low then high, DIV core cycles each
    // ------------------------------------------------------------
    logic [7:0]       div_cnt;
    logic             tck;
    logic             rise;
    logic             fall;
    sbt_state_e       st;
    logic [CNT_W-1:0] left;
    logic [BSR_W-1:0] sh_out;
    logic [BSR_W-1:0] sh_in;
    logic [2:0]       rst_cnt;
    logic             ir_run;
    logic             active;
    logic             tms;
    logic             tdi;

    assign fall = (div_cnt == 8'(DIV - 1)) && tck;
    assign rise = (div_cnt == 8'(DIV - 1)) && !tck;

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !active)
            div_cnt <= 8'h00;
        else if (div_cnt == 8'(DIV - 1))
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !active)
            tck <= 1'b0;
        else if (div_cnt == 8'(DIV - 1))
            tck <= ~tck;
    end

    // ------------------------------------------------------------
    // sequencer; tms/tdi change on tck fall for the port's rise
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            active  <= 1'b0;
            st      <= ST_RESET;
            rst_cnt <= 3'h0;
            ir_run  <= 1'b0;
            left    <= '0;
            sh_out  <= '0;
            sh_in   <= '0;
            tms     <= 1'b1;
            tdi     <= 1'b1;
            done_o  <= 1'b0;
            resp_data_o <= '0;
        end
        else
        begin
            done_o <= 1'b0;
            if (!active && req_i)
            begin
                active  <= 1'b1;
                ir_run  <= req_ir_i;
                left    <= req_len_i;
                rst_cnt <= req_reset_i ? 3'(RESET_TMS_CNT) : 3'h0;
                // reserved codes never leave this end
                sh_out  <= (req_ir_i && req_data_i[1:0] != 2'h0 && req_data_i[2:0] != INS_IDCODE &&
                            req_data_i[2:0] != INS_SAMPLE_Z && req_data_i[2:0] != INS_BYPASS)
                           ? BSR_W'(INS_BYPASS) : req_data_i; // R13
                sh_in   <= '0;
                tms     <= 1'b1;
            end
            else if (active && rise)
            begin
                st <= sbt_next(st, tms);
                if ((st == ST_SH_DR || st == ST_SH_IR))
                    sh_in <= {link.tdo_pin, sh_in[BSR_W-1:1]};
            end
            else if (active && fall)
            begin
                if (rst_cnt != 3'h0)
                begin
                    rst_cnt <= rst_cnt - 3'h1; // R05
                    tms     <= 1'b1;
                    if (rst_cnt == 3'h1)
                        tms <= 1'b0;
                end
                else
                begin
                    case (st)
                        ST_RESET:  tms <= 1'b0;
                        ST_IDLE:   tms <= (left != '0);
                        ST_SEL_DR: tms <= ir_run;
                        ST_SEL_IR: tms <= 1'b0;
                        // the port captures on the next rise, so the first bit waits one edge
                        ST_CAP_DR, ST_CAP_IR: tms <= 1'b0;
                        ST_SH_DR, ST_SH_IR:
                        begin
                            tdi    <= sh_out[0];
                            sh_out <= {1'b1, sh_out[BSR_W-1:1]};
                            left   <= left - CNT_W'(1);
                            tms    <= (left == CNT_W'(1)); // R12
                        end
                        ST_EX1_DR, ST_EX1_IR: tms <= 1'b1;
                        ST_UPD_DR, ST_UPD_IR:
                        begin
                            tms <= 1'b0;
                        end
                        default:   tms <= 1'b1;
                    endcase
                    if ((st == ST_IDLE && left == '0) || (st == ST_RESET && req_reset_i == 1'b0 && left == '0))
                    begin
                        active      <= 1'b0;
                        done_o      <= 1'b1;
                        resp_data_o <= sh_in >> (CNT_W'(BSR_W) - req_len_i);
                    end
                end
            end
        end
    end

    assign busy_o         = active;
    assign link.tck       = tck; // R20
    assign link.tms       = tms;
    assign link.tdi       = tdi;
    assign link.tms_oe_n  = 1'b0;
    assign link.tdi_oe_n  = 1'b0;

endmodule

/* File: verif/sbt_link_properties.sv */
// Purpose: concurrent checks on the scan link between tester and test port
// Assumes: controller state is shadowed from tms; checks start after five tms-high edges
// Notes: boundary data is not modelled here, only the id, bypass and instruction paths
module sbt_link_properties
    import sbt_pkg::*;
#(
    parameter logic [sbt_pkg::ID_W-1:0] ID_VALUE = sbt_pkg::ID_VALUE_DEF
)(
    // link
    input wire logic tck,
    input wire logic tms_pin,
    input wire logic tdi_pin,
    input wire logic tdo_out,
    input wire logic tdo_oe_n,
    // core reset
    input wire logic srst_i
);
    // ----
    // shadow controller
    // ----
    // power-up state is unknown to us, so nothing is judged before a tms reset
    logic [2:0]      tms_cnt = 3'h0;
    logic            sync    = 1'b0;
    sbt_state_e      st;
    logic [IR_W-1:0] ir_cur;
    logic [IR_W-1:0] ir_sh;
    logic [ID_W-1:0] dr_sh;
    logic            tdo_rise;
    logic            oe_rise;

    always_ff @(posedge tck)
    begin
        tms_cnt <= !tms_pin ? 3'h0 : (tms_cnt == 3'h5) ? tms_cnt : tms_cnt + 3'h1;
    end

    always_ff @(posedge tck)
    begin
        if (srst_i)
            sync <= 1'b0;
        else if (tms_pin && tms_cnt == 3'h4)
            sync <= 1'b1;
    end

    always_ff @(posedge tck)
    begin
        st <= (tms_pin && tms_cnt >= 3'h4) ? ST_RESET : sbt_next(st, tms_pin);
    end

    always_ff @(posedge tck)
    begin
        if (st == ST_RESET)
            ir_cur <= INS_IDCODE;
        else if (st == ST_UPD_IR)
            ir_cur <= ir_sh;
    end

    always_ff @(posedge tck)
    begin
        if (st == ST_CAP_IR)
            ir_sh <= {ir_cur[2], IR_CAPTURE};
        else if (st == ST_SH_IR)
            ir_sh <= {tdi_pin, ir_sh[2:1]};
    end

    always_ff @(posedge tck)
    begin
        if (st == ST_CAP_DR)
            dr_sh <= (ir_cur == INS_IDCODE) ? ID_VALUE : '0;
        else if (st == ST_SH_DR && ir_cur == INS_BYPASS)
            dr_sh <= {31'h0, tdi_pin};
        else if (st == ST_SH_DR)
            dr_sh <= {tdi_pin, dr_sh[ID_W-1:1]};
    end

    always_ff @(posedge tck)
    begin
        tdo_rise <= tdo_out;
        oe_rise  <= tdo_oe_n;
    end

    // ----
    // properties
    // ----
    default clocking link_cb @(posedge tck);
    endclocking
    default disable iff (srst_i || !sync);

    tdo_fall_only_a: assert property (@(negedge tck) tdo_out == tdo_rise)
        else $error("tdo changed away from a falling edge");
    oe_fall_only_a: assert property (@(negedge tck) tdo_oe_n == oe_rise)
        else $error("tdo enable changed away from a falling edge");
    drive_in_shift_a: assert property (tdo_oe_n == !(st == ST_SH_IR || st == ST_SH_DR))
        else $error("tdo driven outside a shift state");
    five_high_float_a: assert property (tms_cnt == 3'h5 |-> tdo_oe_n == 1'b1)
        else $error("tdo driven after five tms-high edges");
    ir_capture_a: assert property (st == ST_CAP_IR ##1 st == ST_SH_IR |->
        tdo_out == 1'b1 ##1 (st != ST_SH_IR || tdo_out == 1'b0))
        else $error("capture pattern of instruction register wrong");
    ir_path_a: assert property (st == ST_SH_IR |-> tdo_out == ir_sh[0])
        else $error("instruction shift path wrong");
    dr_path_a: assert property (st == ST_SH_DR && (ir_cur == INS_IDCODE || ir_cur == INS_BYPASS)
        |-> tdo_out == dr_sh[0])
        else $error("data shift path wrong");
    float_until_shift_a: assert property (st == ST_CAP_DR |->
        tdo_oe_n == 1'b1 ##1 (st != ST_SH_DR || tdo_oe_n == 1'b0))
        else $error("tdo enable wrong around capture");
endmodule

/* File: verif/sbt_tap_test.sv */
// Purpose: tester end driving the test port across the scan link
// Assumes: tck is divided from core_clk_i by the tester
// Notes: scenarios are run back to back through one request task
module sbt_tap_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sbt_pkg::*;

    localparam int               LIMIT = 40000;
    localparam logic [BSR_W-1:0] PINS  = {1'b1, {27{4'h6}}};
    localparam logic [BSR_W-1:0] PAT_A = {1'b1, {27{4'h5}}};
    localparam logic [BSR_W-1:0] PAT_B = {1'b0, {27{4'h9}}};

    logic             core_clk_i;
    logic             srst_i;
    logic [BSR_W-1:0] pins_i;
    logic [BSR_W-1:0] pins_o;
    logic             test_drive_o;
    logic             q_float_o;
    logic             req_i;
    logic             req_ir_i;
    logic             req_reset_i;
    logic [CNT_W-1:0] req_len_i;
    logic [BSR_W-1:0] req_data_i;
    logic             busy_o;
    logic             done_o;
    logic [BSR_W-1:0] resp_data_o;
    logic [BSR_W-1:0] resp;
    int               n_mismatch = 0;
    int               n_compared = 0;
    int               cyc        = 0;

    sbt_if link_if();

    sbt_tap sbt_tap_inst (.core_clk_i, .srst_i, .pins_i, .pins_o, .test_drive_o, .q_float_o, .link(link_if));

    sbt_tester #(.DIV(2)) sbt_tester_inst (.core_clk_i, .srst_i, .req_i, .req_ir_i, .req_reset_i, .req_len_i,
        .req_data_i, .busy_o, .done_o, .resp_data_o, .link(link_if));

    sbt_link_properties #(.ID_VALUE(ID_VALUE_DEF)) sbt_link_properties_inst (.tck(link_if.tck),
        .tms_pin(link_if.tms_pin), .tdi_pin(link_if.tdi_pin), .tdo_out(link_if.tdo_out),
        .tdo_oe_n(link_if.tdo_oe_n), .srst_i(srst_i));

    always #25 core_clk_i = ~core_clk_i;

    // a hang counts as a mismatch and ends the run
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ----
    // shared tasks
    // ----
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [BSR_W-1:0] seen, input logic [BSR_W-1:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // entered at a falling edge; leaves time for core outputs to cross
    task automatic scan(input logic rst, input logic ir, input logic [CNT_W-1:0] len, input logic [BSR_W-1:0] d);
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < 100)
        begin
            @(negedge core_clk_i);
            k++;
        end
        if (k == 100)
            n_mismatch++;
        req_i       <= 1'b1;
        req_reset_i <= rst;
        req_ir_i    <= ir;
        req_len_i   <= len;
        req_data_i  <= d;
        @(negedge core_clk_i);
        req_i <= 1'b0;
        k = 0;
        while (done_o !== 1'b1 && k < 4000)
        begin
            @(negedge core_clk_i);
            k++;
        end
        if (k == 4000)
            n_mismatch++;
        resp = resp_data_o;
        repeat (4) @(negedge core_clk_i);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_id_path;
        scan(1'b0, 1'b0, 8'h28, BSR_W'(8'hA5));
        chk(BSR_W'(resp[ID_W-1:0]), BSR_W'(ID_VALUE_DEF));
        chk(BSR_W'(resp[39:32]), BSR_W'(8'hA5));
    endtask

    task automatic t_reset_id;
        scan(1'b1, 1'b0, 8'h00, '0);
        t_id_path();
    endtask

    task automatic t_bypass(input logic [IR_W-1:0] code);
        scan(1'b0, 1'b1, 8'h03, BSR_W'(code));
        chk(BSR_W'(resp[1:0]), BSR_W'(IR_CAPTURE));
        scan(1'b0, 1'b0, 8'h09, BSR_W'(9'h1AB));
        chk(BSR_W'(resp[8:0]), BSR_W'({8'hAB, 1'b0}));
    endtask

    task automatic t_bsr(input logic [IR_W-1:0] code, input logic [BSR_W-1:0] pat, input logic fl);
        scan(1'b0, 1'b1, 8'h03, BSR_W'(code));
        scan(1'b0, 1'b0, 8'h6D, pat);
        chk(resp, PINS);
        if (code != INS_SAMPLE_Z)
            chk(pins_o, pat);
        chk(BSR_W'(test_drive_o), BSR_W'(code == INS_EXTEST));
        chk(BSR_W'(q_float_o), BSR_W'(fl));
    endtask

    // the control cell must float the bus under extest right after a port reset
    task automatic t_preset;
        scan(1'b1, 1'b0, 8'h00, '0);
        scan(1'b0, 1'b1, 8'h03, BSR_W'(INS_EXTEST));
        chk(BSR_W'(q_float_o), BSR_W'(1'b1));
        chk(BSR_W'(test_drive_o), BSR_W'(1'b1));
        scan(1'b0, 1'b1, 8'h03, BSR_W'(INS_IDCODE));
        chk(BSR_W'(q_float_o), BSR_W'(1'b0));
        t_id_path();
    endtask

    initial
    begin
        core_clk_i  = 1'b0;
        srst_i      = 1'b1;
        pins_i      = PINS;
        req_i       = 1'b0;
        req_ir_i    = 1'b0;
        req_reset_i = 1'b0;
        req_len_i   = '0;
        req_data_i  = '0;
        repeat (6) @(negedge core_clk_i);
        srst_i <= 1'b0;
        @(negedge core_clk_i);
        t_reset_id();
        t_bypass(INS_BYPASS);
        t_bypass(3'h3);
        t_bypass(3'h5);
        t_bypass(3'h6);
        t_bsr(INS_SAMPLE, PAT_A, 1'b0);
        t_bsr(INS_EXTEST, PAT_B, 1'b1);
        t_bsr(INS_EXTEST, PAT_A, 1'b0);
        t_bsr(INS_SAMPLE_Z, PAT_B, 1'b1);
        t_preset();
        give_verdict();
    end
endmodule
